// ==== hdl/swwdt_map.svh ====
`ifndef SWWDT_MAP_SVH
`define SWWDT_MAP_SVH

// Register byte offsets
`define SWWDT_OFS_LOAD 12'h000
`define SWWDT_OFS_VALUE 12'h004
`define SWWDT_OFS_CTRL 12'h008
`define SWWDT_OFS_CLR 12'h00C
`define SWWDT_OFS_RIS 12'h010
`define SWWDT_OFS_LOCK 12'hC00

// Field positions
`define SWWDT_CTRL_IRQ_AND_COUNT_EN_BIT 0
`define SWWDT_CTRL_SECOND_EXPIRY_RESET_EN_BIT 1
`define SWWDT_RIS_BIT 0

// Reset values and key
`define SWWDT_LOAD_RST 32'hFFFFFFFF
`define SWWDT_VALUE_RST 32'hFFFFFFFF
`define SWWDT_UNLOCK_KEY 32'h1ACCE551
`define SWWDT_CLR_READ 32'h00000000

// Count clock divider: counter steps once per this many bus cycles
`define SWWDT_DIV_CYCLES 8'h04

`endif

// ==== hdl/swwdt_pkg.sv ====
package swwdt_pkg;
    typedef logic [31:0] swwdt_word_t;
    // Watchdog activity state
    typedef enum logic [1:0] {
        SWWDT_IDLE,
        SWWDT_RUN,
        SWWDT_FIRED
    } swwdt_state_e;
    // Control register contents
    typedef struct packed {
        logic reset_en;
        logic count_en;
    } swwdt_ctrl_s;
endpackage : swwdt_pkg

// ==== hdl/swwdt_top.sv ====
`timescale 1ns/1ns
`include "swwdt_map.svh"

module swwdt_top
    import swwdt_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power mode and watchdog outputs
    input wire logic deep_stop,
    output logic wdog_irq,
    output logic wdog_reset
);
    import swwdt_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [11:0] aw_addr;
    logic aw_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_full;
    logic wr_fire;
    logic addr_ok;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;

    // Address and data latched independently, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= 12'h000;
            w_full <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full <= 1'b0;
            end
        end
    end

    // Known offsets answer OKAY, the rest SLVERR
    always_comb begin
        case (aw_addr)
            `SWWDT_OFS_LOAD, `SWWDT_OFS_VALUE, `SWWDT_OFS_CTRL,
            `SWWDT_OFS_CLR, `SWWDT_OFS_RIS, `SWWDT_OFS_LOCK:
                addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // Write response one cycle after both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic locked;
    swwdt_word_t interval_load;
    swwdt_ctrl_s wd_ctrl;
    logic wr_ok;
    logic wr_load;
    logic wr_ctrl;
    logic wr_clr;
    logic wr_lock;
    logic ctrl_en_rise;
    logic ctrl_en_fall;

    // Partial strobes are ignored so a word is never half updated
    assign wr_ok = wr_fire && (w_strb == 4'hF);
    // Locked: every write except to the lock register is dropped
    assign wr_load = wr_ok && !locked &&
        (aw_addr == `SWWDT_OFS_LOAD);
    assign wr_ctrl = wr_ok && !locked &&
        (aw_addr == `SWWDT_OFS_CTRL);
    assign wr_clr = wr_ok && !locked &&
        (aw_addr == `SWWDT_OFS_CLR);
    assign wr_lock = wr_ok && (aw_addr == `SWWDT_OFS_LOCK);
    assign ctrl_en_rise = wr_ctrl &&
        w_data[`SWWDT_CTRL_IRQ_AND_COUNT_EN_BIT] && !wd_ctrl.count_en;
    assign ctrl_en_fall = wr_ctrl &&
        !w_data[`SWWDT_CTRL_IRQ_AND_COUNT_EN_BIT] && wd_ctrl.count_en;

    // Lock state; only a key or non-key write changes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            locked <= 1'b0;
        end else if (wr_lock) begin
            locked <= (w_data != `SWWDT_UNLOCK_KEY);
        end
    end

    // Interval register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interval_load <= `SWWDT_LOAD_RST;
        end else if (wr_load) begin
            interval_load <= w_data;
        end
    end

    // Control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wd_ctrl <= 2'b00;
        end else if (wr_ctrl) begin
            wd_ctrl.reset_en <= w_data[`SWWDT_CTRL_SECOND_EXPIRY_RESET_EN_BIT];
            wd_ctrl.count_en <= w_data[`SWWDT_CTRL_IRQ_AND_COUNT_EN_BIT];
        end
    end

    // ------------------------------------------------------------
    // Count clock divider
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic tick;

    // Bus-clock based, so count reads need no synchroniser
    assign tick = (div_cnt == `SWWDT_DIV_CYCLES - 8'h01);
    always_ff @(posedge aclk) begin
        if (!aresetn || !wd_ctrl.count_en || deep_stop) begin
            div_cnt <= 8'h00;
        end else if (tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Down counter and expiry logic
    // ------------------------------------------------------------
    swwdt_word_t count_value;
    swwdt_state_e state;
    logic irq_pending;
    logic running;
    logic underflow;
    logic reload;

    // Reset enable alone never makes the block run
    assign running = wd_ctrl.count_en && (state != SWWDT_FIRED);
    // A tick with the counter already at zero, or interval set to zero, is an expiry
    assign underflow = running && !deep_stop && tick &&
        (count_value == 32'h00000000);
    assign reload = wr_clr || ctrl_en_rise ||
        (wr_load && running);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value <= `SWWDT_VALUE_RST;
        end else if (reload) begin
            count_value <= wr_load ? w_data : interval_load;
        end else if (underflow) begin
            count_value <= interval_load;
        end else if (running && tick && !deep_stop) begin
            count_value <= count_value - 32'h00000001;
        end
    end

    // Activity state: fired is terminal until a bus reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SWWDT_IDLE;
        end else begin
            case (state)
                SWWDT_IDLE: if (ctrl_en_rise) state <= SWWDT_RUN;
                SWWDT_RUN: begin
                    if (underflow && irq_pending && wd_ctrl.reset_en) begin
                        state <= SWWDT_FIRED;
                    end else if (ctrl_en_fall) begin
                        state <= SWWDT_IDLE;
                    end
                end
                SWWDT_FIRED: state <= SWWDT_FIRED;
                default: state <= SWWDT_IDLE;
            endcase
        end
    end

    // Pending flag: an expiry in the clearing cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_pending <= 1'b0;
        end else if (underflow || (wr_load && w_data == 32'h0 &&
                running)) begin
            irq_pending <= 1'b1;
        end else if (wr_clr || ctrl_en_fall) begin
            irq_pending <= 1'b0;
        end
    end

    assign wdog_irq = irq_pending && wd_ctrl.count_en;
    // Reset output holds until the system reset lands
    assign wdog_reset = (state == SWWDT_FIRED);

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    swwdt_word_t rd_word;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        case (s_axi_araddr)
            `SWWDT_OFS_LOAD: rd_word = interval_load;
            `SWWDT_OFS_VALUE: rd_word = count_value;
            `SWWDT_OFS_CTRL: rd_word = {30'h0, wd_ctrl};
            `SWWDT_OFS_CLR: rd_word = `SWWDT_CLR_READ;
            `SWWDT_OFS_RIS: rd_word = {31'h0, irq_pending};
            `SWWDT_OFS_LOCK: rd_word = {31'h0, locked};
            default: rd_word = 32'h00000000;
        endcase
    end

    // Reads are never gated by the lock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr[1:0] == 2'b00 &&
                (s_axi_araddr <= `SWWDT_OFS_RIS ||
                s_axi_araddr == `SWWDT_OFS_LOCK)) ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence clr_write_s;
        wr_clr && !underflow;
    endsequence

    // Zero interval while counting, an early expiry
    sequence zero_load_s;
        wr_load && running && w_data == 32'h00000000;
    endsequence

    sequence second_expiry_reset_en_only_s;
        wr_ctrl && !w_data[`SWWDT_CTRL_IRQ_AND_COUNT_EN_BIT] &&
            w_data[`SWWDT_CTRL_SECOND_EXPIRY_RESET_EN_BIT] && state == SWWDT_IDLE;
    endsequence

    sequence_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        clr_write_s |=> !irq_pending && count_value == $past(interval_load))
        else $error("clear did not reload");
    lock_write_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (locked && wr_ok && aw_addr == `SWWDT_OFS_LOAD) |=>
            $stable(interval_load))
        else $error("locked write took effect");
    key_unlock_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_lock && w_data == `SWWDT_UNLOCK_KEY) |=> !locked)
        else $error("key did not unlock");
    enable_load_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_en_rise && !wr_load) |=> count_value == $past(interval_load))
        else $error("enable did not load");
    disable_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_en_fall && !underflow) |=> !irq_pending)
        else $error("disable left flag");
    halt_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (!wd_ctrl.count_en && !reload) |=> $stable(count_value))
        else $error("halted counter moved");
    stop_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (deep_stop && !reload) |=> $stable(count_value))
        else $error("deep stop count moved");
    second_expiry_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (underflow && irq_pending && wd_ctrl.reset_en) |=> wdog_reset[*2])
        else $error("no reset at second expiry");
    first_expiry_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (underflow && !irq_pending) |=> irq_pending &&
        count_value == ($past(wr_load) ? $past(w_data) :
        $past(interval_load)))
        else $error("first expiry wrong");
    ctrl_read_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SWWDT_OFS_CTRL)
        |=> s_axi_rdata[31:2] == 30'h0)
        else $error("control reserved bits set");
    zero_interval_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        zero_load_s |=> irq_pending)
        else $error("zero interval did not flag");
    running_load_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (wr_load && running) |=> count_value == $past(w_data))
        else $error("running interval write not loaded");
    reset_only_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        second_expiry_reset_en_only_s |=> state == SWWDT_IDLE && !wd_ctrl.count_en)
        else $error("reset enable alone started counting");
    status_read_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SWWDT_OFS_RIS)
        |=> s_axi_rdata[31:1] == 31'h0)
        else $error("status reserved bits set");
    lock_read_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `SWWDT_OFS_LOCK)
        |=> s_axi_rdata[31:1] == 31'h0)
        else $error("lock read not zero or one");
    tick_space_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        tick |=> (!tick)[*3])
        else $error("count steps too close");

endmodule : swwdt_top

// ==== test/test_software_watchdog_timer.sv ====
`timescale 1ns/1ns
`include "swwdt_map.svh"

module test_software_watchdog_timer;
    import swwdt_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk, aresetn, deep_stop, wdog_irq, wdog_reset;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int err_count, check_count;
    swwdt_word_t rd, rd2;
    logic [11:0] ofs [5] = '{`SWWDT_OFS_LOAD, `SWWDT_OFS_VALUE,
        `SWWDT_OFS_CTRL, `SWWDT_OFS_RIS, `SWWDT_OFS_LOCK};
    swwdt_word_t rv [5] = '{`SWWDT_LOAD_RST, `SWWDT_VALUE_RST,
        32'h00000000, 32'h00000000, 32'h00000000};

    swwdt_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .deep_stop,
        .wdog_irq, .wdog_reset);

    // 50 ns period
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // ----------------------------------------
    // Report and compare tasks
    // ----------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task wait_fail;
        err_count++;
        $display("Error at %0t: wait ran out %h %h", $time, 1'b1, 1'b0);
        give_verdict();
    endtask : wait_fail

    task check_data(input swwdt_word_t got, input swwdt_word_t exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_data

    task check_resp(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask : check_resp

    // Count is live, so only a window around the expected value holds
    task check_range(input swwdt_word_t got, input swwdt_word_t lo,
        input swwdt_word_t hi);
        check_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("Error at %0t: got %h limit %h", $time, got, hi);
        end
    endtask : check_range

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    // Handshakes are sampled mid-cycle: inputs only move at rising edges
    task axi_write(input logic [11:0] a, input swwdt_word_t d);
        logic aw_t, w_t, b_t;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            b_t = s_axi_bvalid && s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (b_t) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (n == 100) wait_fail();
    endtask : axi_write

    task axi_read(input logic [11:0] a, output swwdt_word_t d);
        logic ar_t, r_t;
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge aclk);
            ar_t = s_axi_arvalid && s_axi_arready;
            r_t = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (r_t) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (n == 100) wait_fail();
    endtask : axi_read

    // Waits for the interrupt (0) or the watchdog reset (1)
    task wait_sig(input bit which);
        int n;
        for (n = 0; n < 300; n++) begin
            @(negedge aclk);
            if ((which ? wdog_reset : wdog_irq) === 1'b1) break;
        end
        if (n == 300) wait_fail();
    endtask : wait_sig

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        aresetn = 1'b0;
        deep_stop = 1'b0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            axi_read(ofs[i], rd);
            check_data(rd, rv[i]);
        end
        $display("test reset_values done");
        axi_write(`SWWDT_OFS_LOAD, 32'h00000040);
        check_resp(rsp, 2'h0);
        axi_read(`SWWDT_OFS_LOAD, rd);
        check_data(rd, 32'h00000040);
        axi_read(`SWWDT_OFS_VALUE, rd);
        check_data(rd, `SWWDT_VALUE_RST);
        axi_write(`SWWDT_OFS_CTRL, 32'h00000002);
        repeat (20) @(posedge aclk);
        axi_read(`SWWDT_OFS_VALUE, rd);
        check_data(rd, `SWWDT_VALUE_RST);
        axi_read(`SWWDT_OFS_CTRL, rd);
        check_data(rd, 32'h00000002);
        $display("test halted done");
        axi_write(`SWWDT_OFS_CTRL, 32'h000000FD);
        axi_read(`SWWDT_OFS_CTRL, rd);
        check_data(rd, 32'h00000001);
        axi_read(`SWWDT_OFS_VALUE, rd);
        check_range(rd, 32'h00000030, 32'h00000040);
        axi_write(`SWWDT_OFS_VALUE, 32'h00000005);
        axi_read(`SWWDT_OFS_VALUE, rd);
        check_range(rd, 32'h00000020, 32'h0000003F);
        axi_write(`SWWDT_OFS_RIS, 32'h00000001);
        axi_read(`SWWDT_OFS_RIS, rd);
        check_data(rd, 32'h00000000);
        axi_write(`SWWDT_OFS_LOAD, 32'h00000100);
        axi_read(`SWWDT_OFS_VALUE, rd);
        check_range(rd, 32'h000000F0, 32'h00000100);
        $display("test start done");
        axi_write(`SWWDT_OFS_LOAD, 32'h00000008);
        wait_sig(1'b0);
        axi_read(`SWWDT_OFS_RIS, rd);
        check_data(rd, 32'h00000001);
        axi_read(`SWWDT_OFS_VALUE, rd);
        check_range(rd, 32'h00000000, 32'h00000008);
        axi_write(`SWWDT_OFS_CLR, 32'hA5A5A5A5);
        axi_read(`SWWDT_OFS_RIS, rd);
        check_data(rd, 32'h00000000);
        wait_sig(1'b0);
        axi_write(`SWWDT_OFS_CTRL, 32'h00000000);
        axi_read(`SWWDT_OFS_RIS, rd);
        check_data(rd, 32'h00000000);
        axi_read(`SWWDT_OFS_VALUE, rd);
        repeat (12) @(posedge aclk);
        axi_read(`SWWDT_OFS_VALUE, rd2);
        check_data(rd2, rd);
        axi_write(`SWWDT_OFS_CTRL, 32'h00000001);
        axi_read(`SWWDT_OFS_VALUE, rd);
        check_range(rd, 32'h00000005, 32'h00000008);
        @(posedge aclk);
        deep_stop <= 1'b1;
        axi_read(`SWWDT_OFS_VALUE, rd);
        repeat (12) @(posedge aclk);
        axi_read(`SWWDT_OFS_VALUE, rd2);
        check_data(rd2, rd);
        @(posedge aclk);
        deep_stop <= 1'b0;
        repeat (12) @(posedge aclk);
        axi_read(`SWWDT_OFS_VALUE, rd2);
        check_range(rd2, 32'h00000001, rd - 32'h00000001);
        $display("test expiry done");
        axi_write(`SWWDT_OFS_LOCK, 32'h00000000);
        axi_read(`SWWDT_OFS_LOCK, rd);
        check_data(rd, 32'h00000001);
        axi_write(`SWWDT_OFS_LOAD, 32'h00000077);
        axi_read(`SWWDT_OFS_LOAD, rd);
        check_data(rd, 32'h00000008);
        axi_write(`SWWDT_OFS_LOCK, `SWWDT_UNLOCK_KEY);
        axi_read(`SWWDT_OFS_LOCK, rd);
        check_data(rd, 32'h00000000);
        axi_write(`SWWDT_OFS_CLR, 32'h00000000);
        axi_read(`SWWDT_OFS_LOCK, rd);
        check_data(rd, 32'h00000000);
        $display("test lock done");
        axi_write(`SWWDT_OFS_CTRL, 32'h00000003);
        axi_write(`SWWDT_OFS_LOAD, 32'h00000000);
        axi_read(`SWWDT_OFS_RIS, rd);
        check_data(rd, 32'h00000001);
        wait_sig(1'b1);
        axi_read(`SWWDT_OFS_VALUE, rd);
        repeat (12) @(posedge aclk);
        axi_read(`SWWDT_OFS_VALUE, rd2);
        check_data(rd2, rd);
        axi_read(12'h020, rd);
        check_resp(rsp, 2'b10);
        check_data(rd, 32'h00000000);
        axi_write(12'h024, 32'h00000001);
        check_resp(rsp, 2'b10);
        $display("test reset_path done");
        give_verdict();
    end
endmodule : test_software_watchdog_timer
